//--- verilog/cell_model_pkg.sv
// Constants, widths and register map of the cell model lookup block
package cell_model_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int TEMP_W = 8;
  localparam int SLOPE_W = 8;
  localparam int CAP_W = 16;
  localparam int FRAC_W = 10;
  localparam int BYTE_W = 8;
  localparam int ABS_W = 24;
  localparam int SEG_N = 4;
  localparam int SPAN_W = 9;
  localparam int SUM_W = 19;
  localparam int PROD_W = CAP_W + SUM_W;
  // ------------------------------------------------------------
  // Scaling: one slope step of 61 ppm is 2^-14, fraction is 2^-10
  // ------------------------------------------------------------
  localparam int SLOPE_SHIFT = 14;
  localparam int FRAC_SHIFT = 10;
  localparam logic signed [TEMP_W-1:0] TOP_TEMP = 8'sh28;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_FULL40 = 8'h00;
  localparam logic [7:0] ADR_AE40 = 8'h04;
  localparam logic [7:0] ADR_BREAK = 8'h08;
  localparam logic [7:0] ADR_SLP_FULL = 8'h0C;
  localparam logic [7:0] ADR_SLP_AE = 8'h10;
  localparam logic [7:0] ADR_SLP_SE = 8'h14;
  localparam logic [7:0] ADR_COND = 8'h18;
  localparam logic [7:0] ADR_CHARGE_VOLTAGE_THRESHOLD = 8'h1C;
  localparam logic [7:0] ADR_VAE = 8'h20;
  localparam logic [7:0] ADR_IAE = 8'h24;
  localparam logic [7:0] ADR_CAP_FULL = 8'h28;
  localparam logic [7:0] ADR_CAP_AE = 8'h2C;
  localparam logic [7:0] ADR_CAP_SE = 8'h30;
  localparam logic [7:0] ADR_STATUS = 8'h34;
  localparam logic [7:0] ADR_ABS_FULL = 8'h38;
  // ------------------------------------------------------------
  // Status bit positions and reset values
  // ------------------------------------------------------------
  localparam int ST_CHG = 0;
  localparam int ST_AEV = 1;
  localparam int ST_AEI = 2;
  localparam logic [CAP_W-1:0] RST_FULL40 = 16'h0000;
  localparam logic [FRAC_W-1:0] RST_AE40 = 10'h000;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

//--- verilog/model_if.sv
// Shared model inputs carried from the register file and the temperature input to the curve evaluators
`timescale 1ns/1ps
interface model_if;
  import cell_model_pkg::*;
  logic signed [TEMP_W-1:0] temp;
  logic signed [TEMP_W-1:0] bp12;
  logic signed [TEMP_W-1:0] bp23;
  logic signed [TEMP_W-1:0] bp34;
  logic [CAP_W-1:0] full40;
  modport src (output temp, bp12, bp23, bp34, full40);
  modport eval (input temp, bp12, bp23, bp34, full40);
endinterface

//--- verilog/curve_eval.sv
// One piecewise-linear model curve evaluated at the present temperature
`timescale 1ns/1ps
module curve_eval
  import cell_model_pkg::*;
(
  model_if.eval m,
  input wire logic [SEG_N*SLOPE_W-1:0] slopes_i,
  input wire logic [CAP_W-1:0] anchor_i,
  output logic [CAP_W-1:0] value_o
);
  logic signed [TEMP_W+1:0] t_eff;
  logic signed [TEMP_W+1:0] hi [SEG_N];
  logic signed [TEMP_W+1:0] lo [SEG_N];
  logic [SPAN_W-1:0] span [SEG_N];
  logic [SUM_W-1:0] prod [SEG_N];
  logic [SUM_W-1:0] sum;
  logic [PROD_W-1:0] scaled;
  logic [PROD_W-1:0] delta;

  // ------------------------------------------------------------
  // Segment bounds, segment 4 on top, segment 1 open to the cold
  // ------------------------------------------------------------
  // Above the top anchor every curve is flat
  assign t_eff = (m.temp > TOP_TEMP) ? 10'(TOP_TEMP) : 10'(m.temp);
  assign hi[3] = 10'(TOP_TEMP);
  assign lo[3] = 10'(m.bp34);
  assign hi[2] = 10'(m.bp34);
  assign lo[2] = 10'(m.bp23);
  assign hi[1] = 10'(m.bp23);
  assign lo[1] = 10'(m.bp12);
  assign hi[0] = 10'(m.bp12);
  assign lo[0] = t_eff;

  // ------------------------------------------------------------
  // Span walked down inside each segment, times its slope
  // ------------------------------------------------------------
  for (genvar k = 0; k < SEG_N; k++) begin : g_seg
    logic signed [TEMP_W+1:0] low_end;
    assign low_end = (t_eff > lo[k]) ? t_eff : lo[k];
    // Empty span when above the segment or bounds misordered
    assign span[k] = (hi[k] > low_end) ? SPAN_W'(hi[k] - low_end) : '0;
    // Widen both factors first so the product keeps all its bits
    assign prod[k] = SUM_W'(slopes_i[k*SLOPE_W +: SLOPE_W]) * SUM_W'(span[k]);
  end

  // Sum of slope-degree products, one slope step per 2^-14
  assign sum = prod[0] + prod[1] + prod[2] + prod[3];
  assign scaled = PROD_W'(m.full40) * PROD_W'(sum);
  assign delta = scaled >> SLOPE_SHIFT;
  // Curve value never goes below zero capacity
  assign value_o = (delta >= PROD_W'(anchor_i)) ? '0
                 : CAP_W'(PROD_W'(anchor_i) - delta);
endmodule

//--- verilog/cell_model_lookup.sv
// Top of the cell model lookup: register file, curve lookup, thresholds
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module cell_model_lookup
  import cell_model_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [TEMP_W-1:0] temperature_i,
  input wire logic [BYTE_W-1:0] cell1_voltage_i,
  input wire logic [BYTE_W-1:0] cell2_voltage_i,
  input wire logic [BYTE_W-1:0] discharge_current_i,
  output logic [CAP_W-1:0] full_cap_o,
  output logic [CAP_W-1:0] active_empty_cap_o,
  output logic [CAP_W-1:0] standby_empty_cap_o,
  output logic [ABS_W-1:0] full_abs_o,
  output logic charge_voltage_reached_o,
  output logic active_empty_voltage_o,
  output logic active_empty_current_o
);
  // ------------------------------------------------------------
  // Parameter registers
  // ------------------------------------------------------------
  logic [CAP_W-1:0] full40_reg;
  logic [FRAC_W-1:0] ae40_reg;
  logic signed [TEMP_W-1:0] breakpoint_seg1_seg2_reg;
  logic signed [TEMP_W-1:0] breakpoint_seg2_seg3_reg;
  logic signed [TEMP_W-1:0] breakpoint_seg3_seg4_reg;
  logic [SEG_N*SLOPE_W-1:0] slope_full_reg;
  logic [SEG_N*SLOPE_W-1:0] slope_ae_reg;
  logic [SEG_N*SLOPE_W-1:0] slope_se_reg;
  logic [BYTE_W-1:0] sense_conductance_reg;
  logic [BYTE_W-1:0] charge_voltage_threshold_reg;
  logic [BYTE_W-1:0] active_empty_voltage_threshold_reg;
  logic [BYTE_W-1:0] active_empty_current_threshold_reg;

  // ------------------------------------------------------------
  // Bus side state and decode
  // ------------------------------------------------------------
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr_now;
  logic [31:0] lane_mask;
  logic [31:0] rd_word;
  logic [2:0] status;

  // ------------------------------------------------------------
  // Lookup results
  // ------------------------------------------------------------
  logic [CAP_W-1:0] full_val;
  logic [CAP_W-1:0] ae_val;
  logic [CAP_W-1:0] se_val;
  logic [CAP_W-1:0] ae_anchor;
  logic [CAP_W+FRAC_W-1:0] ae_anchor_wide;
  logic [BYTE_W:0] cell_sum;
  logic [BYTE_W-1:0] cell_mean;
  logic [ABS_W-1:0] full_abs;

  model_if mif ();

  // ------------------------------------------------------------
  // Byte-lane mask and write merge
  // ------------------------------------------------------------
  // A request is live while cycle and strobe are both up
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land at the edge on which the master sees the ack
  assign wr_now = req & wb_we_i & ack_reg;
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Merge selected lanes of the bus word into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [31:0] mask);
    merge = (old_w & ~mask) | (new_w & mask);
  endfunction

  // ------------------------------------------------------------
  // Register file writes
  // ------------------------------------------------------------
  // Nominal full, active-empty fraction and breakpoints
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full40_reg <= RST_FULL40;
      ae40_reg <= RST_AE40;
      breakpoint_seg1_seg2_reg <= RST_BYTE;
      breakpoint_seg2_seg3_reg <= RST_BYTE;
      breakpoint_seg3_seg4_reg <= RST_BYTE;
    end else if (ce_i && wr_now) begin
      case (wb_adr_i)
        ADR_FULL40: begin
          full40_reg <= CAP_W'(merge(32'(full40_reg), wb_dat_i, lane_mask));
        end
        ADR_AE40: begin
          ae40_reg <= FRAC_W'(merge(32'(ae40_reg), wb_dat_i, lane_mask));
        end
        ADR_BREAK: begin
          // Breakpoints above forty are clamped to forty on write
          breakpoint_seg1_seg2_reg <= clamp_bp(wb_sel_i[0] ? wb_dat_i[7:0]
                                               : breakpoint_seg1_seg2_reg);
          breakpoint_seg2_seg3_reg <= clamp_bp(wb_sel_i[1] ? wb_dat_i[15:8]
                                               : breakpoint_seg2_seg3_reg);
          breakpoint_seg3_seg4_reg <= clamp_bp(wb_sel_i[2] ? wb_dat_i[23:16]
                                               : breakpoint_seg3_seg4_reg);
        end
        default: begin
        end
      endcase
    end
  end

  // Keep a signed breakpoint within minus 128 to plus forty
  function automatic logic signed [TEMP_W-1:0] clamp_bp(input logic signed [TEMP_W-1:0] v);
    clamp_bp = (v > TOP_TEMP) ? TOP_TEMP : v;
  endfunction

  // Slopes of segments one to four, one byte each, lane k is segment k+1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slope_full_reg <= RST_WORD;
      slope_ae_reg <= RST_WORD;
      slope_se_reg <= RST_WORD;
    end else if (ce_i && wr_now) begin
      case (wb_adr_i)
        ADR_SLP_FULL: slope_full_reg <= merge(slope_full_reg, wb_dat_i, lane_mask);
        ADR_SLP_AE: slope_ae_reg <= merge(slope_ae_reg, wb_dat_i, lane_mask);
        ADR_SLP_SE: slope_se_reg <= merge(slope_se_reg, wb_dat_i, lane_mask);
        default: begin
        end
      endcase
    end
  end

  // Application parameters, each one byte in lane zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_conductance_reg <= RST_BYTE;
      charge_voltage_threshold_reg <= RST_BYTE;
      active_empty_voltage_threshold_reg <= RST_BYTE;
      active_empty_current_threshold_reg <= RST_BYTE;
    end else if (ce_i && wr_now && wb_sel_i[0]) begin
      case (wb_adr_i)
        ADR_COND: sense_conductance_reg <= wb_dat_i[7:0];
        ADR_CHARGE_VOLTAGE_THRESHOLD: charge_voltage_threshold_reg <= wb_dat_i[7:0];
        ADR_VAE: active_empty_voltage_threshold_reg <= wb_dat_i[7:0];
        ADR_IAE: active_empty_current_threshold_reg <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read multiplexer, unmapped addresses read zero
  // ------------------------------------------------------------
  assign rd_word =
    (wb_adr_i == ADR_FULL40) ? 32'(full40_reg) :
    (wb_adr_i == ADR_AE40) ? 32'(ae40_reg) :
    (wb_adr_i == ADR_BREAK) ? {8'h00, breakpoint_seg3_seg4_reg,
                               breakpoint_seg2_seg3_reg, breakpoint_seg1_seg2_reg} :
    (wb_adr_i == ADR_SLP_FULL) ? slope_full_reg :
    (wb_adr_i == ADR_SLP_AE) ? slope_ae_reg :
    (wb_adr_i == ADR_SLP_SE) ? slope_se_reg :
    (wb_adr_i == ADR_COND) ? 32'(sense_conductance_reg) :
    (wb_adr_i == ADR_CHARGE_VOLTAGE_THRESHOLD) ? 32'(charge_voltage_threshold_reg) :
    (wb_adr_i == ADR_VAE) ? 32'(active_empty_voltage_threshold_reg) :
    (wb_adr_i == ADR_IAE) ? 32'(active_empty_current_threshold_reg) :
    (wb_adr_i == ADR_CAP_FULL) ? 32'(full_cap_o) :
    (wb_adr_i == ADR_CAP_AE) ? 32'(active_empty_cap_o) :
    (wb_adr_i == ADR_CAP_SE) ? 32'(standby_empty_cap_o) :
    (wb_adr_i == ADR_STATUS) ? 32'(status) :
    (wb_adr_i == ADR_ABS_FULL) ? 32'(full_abs_o) :
    RST_WORD;

  // Status word shows the threshold comparisons
  assign status = {active_empty_current_o, active_empty_voltage_o,
                   charge_voltage_reached_o};

  // ------------------------------------------------------------
  // Wishbone answer: ack one cycle after the request, for one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= RST_WORD;
    end else if (ce_i) begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) begin
        rdata_reg <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ------------------------------------------------------------
  // Shared inputs to the three curve evaluators
  // ------------------------------------------------------------
  assign mif.temp = temperature_i;
  assign mif.bp12 = breakpoint_seg1_seg2_reg;
  assign mif.bp23 = breakpoint_seg2_seg3_reg;
  assign mif.bp34 = breakpoint_seg3_seg4_reg;
  assign mif.full40 = full40_reg;

  // Active-empty anchor is the fraction of full at forty degrees
  assign ae_anchor_wide = (CAP_W+FRAC_W)'(full40_reg) * (CAP_W+FRAC_W)'(ae40_reg);
  assign ae_anchor = CAP_W'(ae_anchor_wide >> FRAC_SHIFT);

  // ------------------------------------------------------------
  // Three model curves share one evaluator design
  // ------------------------------------------------------------
  // Full curve anchored at the nominal full value
  curve_eval u_full (
    .m(mif),
    .slopes_i(slope_full_reg),
    .anchor_i(full40_reg),
    .value_o(full_val)
  );

  // Active-empty curve anchored at its stored fraction
  curve_eval u_ae (
    .m(mif),
    .slopes_i(slope_ae_reg),
    .anchor_i(ae_anchor),
    .value_o(ae_val)
  );

  // Standby-empty curve anchored at zero, with no stored anchor
  curve_eval u_se (
    .m(mif),
    .slopes_i(slope_se_reg),
    .anchor_i(RST_FULL40),
    .value_o(se_val)
  );

  // ------------------------------------------------------------
  // Cell mean and absolute scaling
  // ------------------------------------------------------------
  // Mean of both cell inputs, not either cell alone
  assign cell_sum = (BYTE_W+1)'(cell1_voltage_i) + (BYTE_W+1)'(cell2_voltage_i);
  assign cell_mean = BYTE_W'(cell_sum >> 1);
  // Full capacity in voltage-hours times conductance gives charge
  assign full_abs = ABS_W'(full_val) * ABS_W'(sense_conductance_reg);

  // ------------------------------------------------------------
  // Registered lookup results
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_cap_o <= RST_FULL40;
      active_empty_cap_o <= RST_FULL40;
      standby_empty_cap_o <= RST_FULL40;
      full_abs_o <= '0;
    end else if (ce_i) begin
      full_cap_o <= full_val;
      active_empty_cap_o <= ae_val;
      standby_empty_cap_o <= se_val;
      full_abs_o <= full_abs;
    end
  end

  // ------------------------------------------------------------
  // Registered threshold comparisons
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_voltage_reached_o <= 1'b0;
      active_empty_voltage_o <= 1'b0;
      active_empty_current_o <= 1'b0;
    end else if (ce_i) begin
      // Voltage side of the full test
      charge_voltage_reached_o <= cell_mean >= charge_voltage_threshold_reg;
      // Below the minimum operating voltage
      active_empty_voltage_o <= cell_mean < active_empty_voltage_threshold_reg;
      // Discharge at least as heavy as the active load
      active_empty_current_o <= discharge_current_i >= active_empty_current_threshold_reg;
    end
  end
endmodule

//--- testbench/cell_model_lookup_monitor.sv
// Concurrent checks on the ports of the cell model lookup block
`timescale 1ns/1ps
module cell_model_monitor
  import cell_model_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic signed [TEMP_W-1:0] temperature_i,
  input wire logic [BYTE_W-1:0] cell1_voltage_i,
  input wire logic [BYTE_W-1:0] cell2_voltage_i,
  input wire logic [BYTE_W-1:0] discharge_current_i,
  input wire logic [CAP_W-1:0] full_cap_o,
  input wire logic [CAP_W-1:0] active_empty_cap_o,
  input wire logic [CAP_W-1:0] standby_empty_cap_o,
  input wire logic [ABS_W-1:0] full_abs_o,
  input wire logic charge_voltage_reached_o,
  input wire logic active_empty_voltage_o,
  input wire logic active_empty_current_o
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [1:0] up_cnt;
  logic [8:0] cell_sum;
  logic hot;
  logic req;
  // Sum of both cells, hot region and bus request
  assign cell_sum = {1'b0, cell1_voltage_i} + {1'b0, cell2_voltage_i};
  assign hot = (temperature_i >= TOP_TEMP);
  assign req = wb_cyc_i && wb_stb_i;
  // Edges since reset, so that past values never reach into reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (req && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered after one cycle");
  a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_no_request: assert property (!req && ce_i |=> !wb_ack_o)
    else $error("ack without request");
  a_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && full_cap_o == 16'h0000
    && full_abs_o == 24'h00_0000 && !charge_voltage_reached_o && !active_empty_current_o)
    else $error("outputs not clear after reset");
  a_standby_hot_zero: assert property (ce_i && hot |=> standby_empty_cap_o == 16'h0000)
    else $error("standby empty not zero when hot");
  a_hot_flat_curves: assert property ((ce_i && hot && !wb_we_i) ##1 (ce_i && hot && !wb_we_i)
    |=> $stable(full_cap_o) && $stable(active_empty_cap_o) && $stable(full_abs_o))
    else $error("curve moved above the top temperature");
  a_mean_cell_flags: assert property (up_cnt == 2'h3 && ce_i && $past(ce_i) && !wb_we_i
    && !$past(wb_we_i) && cell_sum == $past(cell_sum) && $stable(discharge_current_i)
    |=> $stable({charge_voltage_reached_o, active_empty_voltage_o, active_empty_current_o}))
    else $error("flags changed with same cell sum");
  a_cold_monotone: assert property (up_cnt == 2'h3 && ce_i && $past(ce_i) && !wb_we_i
    && !$past(wb_we_i) && temperature_i < $past(temperature_i)
    |=> full_cap_o <= $past(full_cap_o) && active_empty_cap_o <= $past(active_empty_cap_o))
    else $error("curve rose while cooling");
  // Main scenarios
  c_write_acked: cover property (req && wb_we_i && wb_ack_o);
  c_hot: cover property (ce_i && hot);
  c_empty_voltage: cover property (active_empty_voltage_o && !charge_voltage_reached_o);
endmodule

bind cell_model_lookup cell_model_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .temperature_i(temperature_i), .cell1_voltage_i(cell1_voltage_i),
  .cell2_voltage_i(cell2_voltage_i), .discharge_current_i(discharge_current_i),
  .full_cap_o(full_cap_o), .active_empty_cap_o(active_empty_cap_o),
  .standby_empty_cap_o(standby_empty_cap_o), .full_abs_o(full_abs_o),
  .charge_voltage_reached_o(charge_voltage_reached_o),
  .active_empty_voltage_o(active_empty_voltage_o),
  .active_empty_current_o(active_empty_current_o));

//--- testbench/tb_top.sv
// Self-checking bench for the cell model lookup block
`timescale 1ns/1ps
module tb_top;
  import cell_model_pkg::*;
  localparam int F40 = 4096;
  localparam logic [31:0] SL_FULL = 32'h0E13_333B;
  localparam logic [31:0] SL_AE = 32'h050B_1227;
  localparam logic [31:0] SL_SE = 32'h0304_0717;
  logic clk_i, rst_i, ce_i, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic signed [7:0] temp;
  logic [7:0] c1, c2, idis;
  logic [15:0] full_cap, ae_cap, se_cap, fe;
  logic [23:0] full_abs;
  logic chg, aev, aei;
  logic [2:0] fx;
  int fails, n_compared;
  logic [7:0] wa [11] = '{ADR_FULL40, ADR_AE40, ADR_BREAK, ADR_BREAK, ADR_SLP_FULL,
    ADR_SLP_AE, ADR_SLP_SE, ADR_COND, ADR_CHARGE_VOLTAGE_THRESHOLD, ADR_VAE, ADR_IAE};
  logic [31:0] wd [11] = '{32'hFFFF_1000, 32'h0000_FD00, 32'h0050_00F4, 32'h0012_00F4,
    SL_FULL, SL_AE, SL_SE, 32'hFFFF_FF32, 32'h1234_56D7, 32'h0000_0099, 32'h0000_0040};
  logic [31:0] wx [11] = '{32'h0000_1000, 32'h0000_0100, 32'h0028_00F4, 32'h0012_00F4,
    SL_FULL, SL_AE, SL_SE, 32'h0000_0032, 32'h0000_00D7, 32'h0000_0099, 32'h0000_0040};
  logic signed [7:0] tl [11] = '{8'sh64, 8'sh28, 8'sh27, 8'sh19, 8'sh12, 8'sh05, 8'sh00,
    8'shF4, 8'shF3, 8'shC4, 8'sh80};
  logic [7:0] fl [4][3] = '{'{8'hD7, 8'hD7, 8'h40}, '{8'hD8, 8'hD5, 8'h3F},
    '{8'h96, 8'h9C, 8'h00}, '{8'hA0, 8'h91, 8'hC8}};

  cell_model_lookup i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .temperature_i(temp), .cell1_voltage_i(c1),
    .cell2_voltage_i(c2), .discharge_current_i(idis), .full_cap_o(full_cap),
    .active_empty_cap_o(ae_cap), .standby_empty_cap_o(se_cap), .full_abs_o(full_abs),
    .charge_voltage_reached_o(chg), .active_empty_voltage_o(aev),
    .active_empty_current_o(aei));

  // ------------------------------------------------------------
  // Tasks and reference model
  // ------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // Walk down from the top anchor, slope times span per segment
  function automatic logic [15:0] curve(input int anchor, input logic [31:0] sl, input int t);
    int e [5];
    int sum;
    int lo;
    int v;
    e = '{-1000, -12, 0, 18, 40};
    sum = 0;
    if (t > 40) t = 40;
    for (int k = 0; k < 4; k++) begin
      lo = (t > e[k]) ? t : e[k];
      if (e[k+1] > lo) sum += int'(sl[8*k +: 8]) * (e[k+1] - lo);
    end
    v = anchor - ((F40 * sum) >> 14);
    return (v < 0) ? 16'h0000 : 16'(v);
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 0; rst_i = 1; ce_i = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'hF;
    wdat = 32'h0000_0000; temp = 8'sh19; c1 = 8'h00; c2 = 8'h00; idis = 8'h00;
    fails = 0; n_compared = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 'h3C; a += 4) begin
      xfer(8'(a), 1'b0, 32'h0000_0000);
      // Zero thresholds after reset: mean and current meet them, status reads 5
      check(q, (a == 'h34) ? 32'h0000_0005 : 32'h0000_0000);
    end
    for (int i = 0; i < 11; i++) begin
      xfer(wa[i], 1'b1, wd[i]);
      xfer(wa[i], 1'b0, 32'h0000_0000);
      check(q, wx[i]);
    end
    xfer(8'h3C, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h3C, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      temp <= tl[i];
      repeat (2) @(posedge clk_i);
      fe = curve(F40, SL_FULL, int'(tl[i]));
      check({16'h0000, full_cap}, {16'h0000, fe});
      check({16'h0000, ae_cap}, {16'h0000, curve((F40 * 256) >> 10, SL_AE, int'(tl[i]))});
      check({16'h0000, se_cap}, {16'h0000, curve(0, SL_SE, int'(tl[i]))});
      check({8'h00, full_abs}, {8'h00, 24'(int'(fe) * 'h32)});
      xfer(ADR_CAP_FULL, 1'b0, 32'h0000_0000);
      check(q, {16'h0000, fe});
    end
    xfer(ADR_CAP_FULL, 1'b1, 32'hFFFF_FFFF);
    xfer(ADR_CAP_FULL, 1'b0, 32'h0000_0000);
    check(q, {16'h0000, fe});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      c1 <= fl[i][0]; c2 <= fl[i][1]; idis <= fl[i][2];
      repeat (2) @(posedge clk_i);
      fx[0] = ((int'(fl[i][0]) + int'(fl[i][1])) / 2) >= 'hD7;
      fx[1] = ((int'(fl[i][0]) + int'(fl[i][1])) / 2) < 'h99;
      fx[2] = fl[i][2] >= 8'h40;
      check({29'h0, aei, aev, chg}, {29'h0, fx});
      xfer(ADR_STATUS, 1'b0, 32'h0000_0000);
      check(q, {29'h0, fx});
    end
    @(posedge clk_i);
    ce_i <= 1'b0;
    temp <= 8'sh28;
    repeat (3) @(posedge clk_i);
    check({16'h0000, full_cap}, {16'h0000, fe});
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({16'h0000, full_cap}, 32'h0000_1000);
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end
endmodule
